// ### program_sequencer_vectoring_tb.sv
// self-checking bench for the program sequencer
// assumes the design files, the rom model and the checker are compiled first
`timescale 1ns/1ps
`include "psv_consts.svh"

module program_sequencer_vectoring_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [11:0] A_PC_LOW = `PSV_ADDR(`PSV_IDX_PC_LOW);
	localparam logic [11:0] A_EN = `PSV_ADDR(`PSV_IDX_INT_EN);
	localparam logic [11:0] A_FLAG = `PSV_ADDR(`PSV_IDX_INT_FLAG);
	localparam logic [1:0] OK = `PSV_RESP_OKAY;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [12:0] rom_addr, instr_addr, pre_end;
	logic [12:0] xfer_target = 13'h0;
	logic [15:0] rom_data, instr_word;
	logic instr_valid, int_ack, stack_full;
	logic [3:0] phase;
	logic [2:0] xfer_op = 3'h0;
	logic int_n_pin = 1'b1;
	logic [3:0] tmr_ovf = 4'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_count = 0;
	int total_checks = 0;

	psv_sequencer dut (.core_clk, .sys_rst, .rom_addr, .rom_data, .instr_word, .instr_addr, .instr_valid, .phase,
		.xfer_op, .xfer_target, .int_n_pin, .tmr_ovf, .int_ack, .stack_full, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	psv_rom_model u_rom (.rom_addr, .rom_data);

	initial forever #20 core_clk = ~core_clk;
	// pc just before each cycle end: what an interrupt pushes
	always @(posedge core_clk) if (phase === 4'h8) pre_end <= rom_addr;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] rom_word(input logic [12:0] a);
		return {3'h5, a} ^ 16'h3C00;
	endfunction
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// settled values are looked at on the falling edge
	task automatic at_phase(input logic [3:0] p);
		do @(negedge core_clk); while (phase !== p);
	endtask
	// execute unit answer for the next valid instruction, held through the cycle end
	task automatic exec(input logic [2:0] op, input logic [12:0] tgt);
		at_phase(4'h4);
		while (instr_valid !== 1'b1)
			at_phase(4'h4);
		@(posedge core_clk);
		xfer_op <= op;
		xfer_target <= tgt;
		@(posedge core_clk);
		xfer_op <= 3'h0;
		@(negedge core_clk);
	endtask
	task automatic wait_ack();
		int n;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (int_ack !== 1'b1 && n < 200);
		check("ack seen", int_ack, 1'b1);
	endtask
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 50);
		check("bvalid", s_axi_bvalid, 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, er);
	endtask
	task automatic axi_read(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 50);
		check("rvalid", s_axi_rvalid, 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		check("rresp", s_axi_rresp, er);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset();
		logic [31:0] d;
		check("pc at reset", rom_addr, 13'h0);
		at_phase(4'h8);
		@(negedge core_clk);
		check("first addr", instr_addr, 13'h0);
		check("first word", instr_word, rom_word(13'h0));
		check("next fetch", rom_addr, 13'h1);
		axi_read(A_EN, OK, d);
		check("enable reset", d, 32'h0);
		axi_read(12'h040, `PSV_RESP_SLVERR, d);
		check("unmapped data", d, 32'h0);
		$display("test reset done");
	endtask
	task automatic test_flow();
		int n;
		exec(3'h1, 13'h1ABC);
		check("jump pc", rom_addr, 13'h1ABC);
		check("jump dummy", instr_valid, 1'b0);
		at_phase(4'h8);
		@(negedge core_clk);
		check("target word", instr_word, rom_word(13'h1ABC));
		exec(3'h5, 13'h0);
		check("skip pc", rom_addr, 13'h1ABE);
		exec(3'h2, 13'h0200);
		check("call pc", rom_addr, 13'h0200);
		exec(3'h3, 13'h0);
		check("return pc", rom_addr, 13'h1ABF);
		at_phase(4'h1);
		axi_write(A_PC_LOW, 32'h55, OK);
		n = 0;
		while (instr_addr !== 13'h1A55 && n < 3)
		begin
			at_phase(4'h8);
			@(negedge core_clk);
			n++;
		end
		check("short jump", instr_addr, 13'h1A55);
		$display("test flow done");
	endtask
	task automatic test_irq();
		logic [12:0] vec [5] = '{13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014};
		logic [12:0] ret_pc;
		logic [31:0] d;
		logic seen;
		// sources on, global off, so every request is pending at once
		axi_write(A_EN, 32'h3E, OK);
		@(posedge core_clk);
		tmr_ovf <= 4'hF;
		int_n_pin <= 1'b0;
		@(posedge core_clk);
		tmr_ovf <= 4'h0;
		repeat (6) @(posedge core_clk);
		int_n_pin <= 1'b1;
		axi_read(A_FLAG, OK, d);
		check("flags held", d[4:0], 5'h1F);
		axi_write(A_EN, 32'h3F, OK);
		for (int i = 0; i < 5; i++)
		begin
			wait_ack();
			ret_pc = pre_end;
			check("vector", rom_addr, vec[i]);
			exec(3'h4, 13'h0);
			check("reti pc", rom_addr, ret_pc);
		end
		for (int i = 0; i < 8; i++)
			exec(3'h2, {5'h03, i[3:0], 4'h0});
		check("stack full", stack_full, 1'b1);
		@(posedge core_clk);
		tmr_ovf <= 4'h2;
		@(posedge core_clk);
		tmr_ovf <= 4'h0;
		seen = 1'b0;
		repeat (16)
		begin
			@(negedge core_clk);
			seen = seen | (int_ack === 1'b1);
		end
		check("ack withheld", seen, 1'b0);
		exec(3'h3, 13'h0);
		wait_ack();
		check("served after ret", rom_addr, 13'h000C);
		// both-edge mode: a rise sets again a flag that software has just cleared
		axi_write(A_EN, 32'h42, OK);
		int_n_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		axi_write(A_FLAG, 32'h1, OK);
		axi_read(A_FLAG, OK, d);
		check("flag cleared", d[4:0], 5'h00);
		int_n_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		axi_read(A_FLAG, OK, d);
		check("rise flag", d[4:0], 5'h01);
		$display("test irq done");
	endtask

	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		test_reset();
		test_flow();
		test_irq();
		give_verdict();
	end
	initial
	begin
		#(40 * 20000);
		err_count++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule // program_sequencer_vectoring_tb

// ### psv_consts.svh
// constants of the program sequencer: timing, vectors, register indices and field positions
// assumes nothing; included by every design file that needs a figure
`ifndef PSV_CONSTS_SVH
`define PSV_CONSTS_SVH

// ----------------------------------------
// timing and widths
// ----------------------------------------
`define PSV_PHASES 4
`define PSV_LAST_PHASE 3
`define PSV_PHASE_RESET 4'h1
`define PSV_PC_W 13
`define PSV_ROM_W 16
`define PSV_ROM_WORDS 8192
`define PSV_STACK_DEPTH 4'h8
`define PSV_INT_SRCS 5

// ----------------------------------------
// program counter values
// ----------------------------------------
`define PSV_PC_RESET 13'h0000
`define PSV_VEC_EXT 13'h0004
`define PSV_VEC_TMR0 13'h0008
`define PSV_VEC_TMR1 13'h000C
`define PSV_VEC_TMR2 13'h0010
`define PSV_VEC_TMR3 13'h0014

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define PSV_AXI_AW 12
`define PSV_IDX_PC_LOW 8'h06
`define PSV_IDX_INT_EN 8'h20
`define PSV_IDX_INT_FLAG 8'h21
`define PSV_IDX_STATUS 8'h22
`define PSV_ADDR(idx) {2'h0, (idx), 2'h0}

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PSV_EN_GLOBAL 0
`define PSV_EN_SRC_LSB 1
`define PSV_EN_SRC_MSB 5
`define PSV_EN_BOTH_EDGE 6
`define PSV_EN_RESET 7'h00
`define PSV_FLAG_RESET 5'h00
`define PSV_RESP_OKAY 2'h0
`define PSV_RESP_SLVERR 2'h2

`endif

// ### psv_core_if.sv
// internal carrier between sequencer, phase generator and return stack
// assumes all three parties run on the same core clock
`timescale 1ns/1ps
`include "psv_consts.svh"

interface psv_core_if;
	logic [`PSV_PHASES-1:0] phase;
	logic push;
	logic pop;
	psv_pkg::psv_pc_t push_data;
	psv_pkg::psv_pc_t top_data;
	logic full;
	logic [3:0] count;

	modport phase_gen (output phase);
	modport stack (input push, input pop, input push_data, output top_data, output full, output count);
	modport seq (input phase, input top_data, input full, input count, output push, output pop, output push_data);
endinterface

// ### psv_phase.sv
// four-phase instruction cycle generator
// assumes a synchronous active-high reset on the core clock
`timescale 1ns/1ps
`include "psv_consts.svh"

module psv_phase (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// phases out
	psv_core_if.phase_gen core
);
	logic [`PSV_PHASES-1:0] phase_ff;
	logic [`PSV_PHASES-1:0] nxt_phase;

	// one-hot ring: phases never overlap and repeat every four clocks
	assign nxt_phase = {phase_ff[`PSV_PHASES-2:0], phase_ff[`PSV_PHASES-1]}; // RULE1 RULE2

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			phase_ff <= `PSV_PHASE_RESET;
		else
			phase_ff <= nxt_phase;
	end

	assign core.phase = phase_ff;
endmodule // psv_phase

// ### psv_pkg.sv
// types shared by the program sequencer files
// assumes psv_consts.svh is on the include path
`include "psv_consts.svh"

package psv_pkg;
	typedef logic [`PSV_PC_W-1:0] psv_pc_t;
	// codes 0..5 in this order are what the execute unit drives on xfer_op
	typedef enum logic [2:0] {
		psv_xfer_none,
		psv_xfer_jump,
		psv_xfer_call,
		psv_xfer_ret,
		psv_xfer_reti,
		psv_xfer_skip
	} psv_xfer_e;
endpackage

// ### psv_rom_model.sv
// behavioural program rom of 8192 sixteen-bit words, asynchronous read
// assumes the sequencer samples rom_data at the cycle-end edge
`timescale 1ns/1ps

module psv_rom_model (
	// fetch address
	input wire logic [12:0] rom_addr,
	// word out
	output logic [15:0] rom_data
);
	// ----------------------------------------
	// contents
	// ----------------------------------------
	// each word carries its own address, so a wrong fetch shows in the word
	assign rom_data = {3'h5, rom_addr} ^ 16'h3C00;
endmodule // psv_rom_model

// ### psv_sequencer.sv
// program sequencer: phase timing, fetch/execute pipeline, program counter and vectoring
// assumes an asynchronous-read program rom, an execute unit on the same clock, axi4-lite master
//
// What this block does
// RULE1: four non-overlapping one-hot phases sequence every instruction cycle.
// RULE2: one instruction cycle is exactly four core clocks.
// RULE3: fetch next word while the previous word executes; one instruction per cycle.
// RULE4: any pc change discards the prefetched word, giving a dummy cycle.
// RULE5: program counter is thirteen bits and addresses rom words.
// RULE6: after each fetch the pc advances by one.
// RULE7: reset clears the pc so execution starts at zero.
// RULE8: enabled external pin interrupt with stack not full vectors to 004H.
// RULE9: enabled timer 0 overflow with stack not full vectors to 008H.
// RULE10: enabled timer 1 overflow with stack not full vectors to 00CH.
// RULE11: enabled timer 2 overflow with stack not full vectors to 010H.
// RULE12: enabled timer 3 overflow with stack not full vectors to 014H.
// RULE13: taken skip drops the fetched word and continues at pc plus two.
// RULE14: writing the pc low byte replaces bits 7:0, keeping the page.
// RULE15: jump and call load all thirteen bits from the target.
// RULE16: return reloads all thirteen bits from the stack top.
// RULE17: program memory is 8192 words of sixteen bits.
// RULE18: call or interrupt acknowledge pushes the pc before transferring.
// RULE19: full stack keeps request flags but holds acknowledge until a return.
// RULE20: simultaneous requests are served lowest vector first, others stay pending.
`timescale 1ns/1ps
`include "psv_consts.svh"

module psv_sequencer (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// program rom
	output logic [`PSV_PC_W-1:0] rom_addr,
	input wire logic [`PSV_ROM_W-1:0] rom_data,
	// execute unit
	output logic [`PSV_ROM_W-1:0] instr_word,
	output logic [`PSV_PC_W-1:0] instr_addr,
	output logic instr_valid,
	output logic [`PSV_PHASES-1:0] phase,
	input wire logic [2:0] xfer_op,
	input wire logic [`PSV_PC_W-1:0] xfer_target,
	// interrupt sources
	input wire logic int_n_pin,
	input wire logic [3:0] tmr_ovf,
	output logic int_ack,
	output logic stack_full,
	// axi4-lite slave
	input wire logic [`PSV_AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PSV_AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------
	// submodules
	// ----------------------------------------
	psv_core_if core ();

	psv_phase u_phase (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.core(core.phase_gen)
	);

	psv_stack u_stack (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.core(core.stack)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	psv_pkg::psv_pc_t pc_ff;
	logic [`PSV_ROM_W-1:0] instr_word_ff;
	psv_pkg::psv_pc_t instr_addr_ff;
	logic instr_valid_ff;
	logic lowb_pend_ff;
	logic [7:0] lowb_data_ff;
	logic glob_en_ff;
	logic [`PSV_INT_SRCS-1:0] src_en_ff;
	logic both_edge_ff;
	logic [`PSV_INT_SRCS-1:0] flag_ff;
	logic int_ack_ff;
	logic int_s1_ff;
	logic int_s2_ff;
	logic int_s3_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [`PSV_AXI_AW-1:0] aw_addr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// ----------------------------------------
	// pipeline decode
	// ----------------------------------------
	// everything in the pipeline moves on the last phase of the instruction cycle;
	// the rom has four clocks to settle after the address changes
	wire cyc_end = core.phase[`PSV_LAST_PHASE]; // RULE1 RULE2
	psv_pkg::psv_xfer_e op_in;
	psv_pkg::psv_xfer_e op_eff;
	assign op_in = psv_pkg::psv_xfer_e'(xfer_op);
	// a dummy cycle executes nothing, so its transfer code is ignored
	assign op_eff = instr_valid_ff ? op_in : psv_pkg::psv_xfer_none; // RULE4
	wire op_none = (op_eff == psv_pkg::psv_xfer_none);
	wire op_call = (op_eff == psv_pkg::psv_xfer_call);
	wire op_jmp = (op_eff == psv_pkg::psv_xfer_jump) | op_call;
	wire op_reti = (op_eff == psv_pkg::psv_xfer_reti);
	wire op_ret = (op_eff == psv_pkg::psv_xfer_ret) | op_reti;
	wire op_skip = (op_eff == psv_pkg::psv_xfer_skip);

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	// the pin is asynchronous; edges are found on the second and third flops only
	wire ext_fall = int_s3_ff & ~int_s2_ff;
	wire ext_rise = ~int_s3_ff & int_s2_ff;
	wire ext_evt = ext_fall | (both_edge_ff & ext_rise);
	wire [`PSV_INT_SRCS-1:0] int_evt = {tmr_ovf, ext_evt};
	wire [`PSV_INT_SRCS-1:0] int_req = flag_ff & src_en_ff & {`PSV_INT_SRCS{glob_en_ff & ~core.full}}; // RULE19
	// lowest set bit is the lowest vector
	wire [`PSV_INT_SRCS-1:0] int_grant = int_req & (~int_req + 5'h01); // RULE20
	// a software pc write or an executing transfer goes first; the request simply waits
	wire take_int = cyc_end & op_none & ~lowb_pend_ff & (|int_req);
	wire [`PSV_PC_W-1:0] int_vec =
		int_grant[0] ? `PSV_VEC_EXT : // RULE8
		int_grant[1] ? `PSV_VEC_TMR0 : // RULE9
		int_grant[2] ? `PSV_VEC_TMR1 : // RULE10
		int_grant[3] ? `PSV_VEC_TMR2 : // RULE11
		`PSV_VEC_TMR3; // RULE12

	// ----------------------------------------
	// program counter
	// ----------------------------------------
	wire [`PSV_PC_W-1:0] pc_inc = pc_ff + 13'h0001; // RULE6
	wire [`PSV_PC_W-1:0] pc_short = {pc_ff[`PSV_PC_W-1:8], lowb_data_ff}; // RULE14
	wire redirect = ~op_none | lowb_pend_ff | take_int; // RULE4
	wire [`PSV_PC_W-1:0] nxt_pc =
		op_jmp ? xfer_target : // RULE15
		op_ret ? core.top_data : // RULE16
		op_skip ? pc_inc : // RULE13
		lowb_pend_ff ? pc_short : // RULE14
		take_int ? int_vec :
		pc_inc; // RULE6
	wire lowb_apply = cyc_end & op_none & lowb_pend_ff;

	// the return address is the word being fetched now, whether call or interrupt
	assign core.push = cyc_end & (op_call | take_int); // RULE18
	assign core.pop = cyc_end & op_ret; // RULE16
	assign core.push_data = pc_ff; // RULE18

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pc_ff <= `PSV_PC_RESET; // RULE7
		else if (cyc_end)
			pc_ff <= nxt_pc; // RULE5
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			instr_word_ff <= 16'h0000;
			instr_addr_ff <= `PSV_PC_RESET;
			instr_valid_ff <= 1'b0;
		end
		else if (cyc_end)
		begin
			instr_word_ff <= rom_data; // RULE3 RULE17
			instr_addr_ff <= pc_ff;
			instr_valid_ff <= ~redirect; // RULE4 RULE13
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire wr_lane0 = wr_fire & wstrb_ff[0];
	wire hit_w_lowb = (aw_addr_ff == `PSV_ADDR(`PSV_IDX_PC_LOW));
	wire hit_w_en = (aw_addr_ff == `PSV_ADDR(`PSV_IDX_INT_EN));
	wire hit_w_flag = (aw_addr_ff == `PSV_ADDR(`PSV_IDX_INT_FLAG));
	wire hit_w_stat = (aw_addr_ff == `PSV_ADDR(`PSV_IDX_STATUS));
	wire hit_w_any = hit_w_lowb | hit_w_en | hit_w_flag | hit_w_stat;
	wire wr_lowb = wr_lane0 & hit_w_lowb;
	wire wr_en = wr_lane0 & hit_w_en;
	wire [`PSV_INT_SRCS-1:0] sw_clr = (wr_lane0 & hit_w_flag) ? wdata_ff[`PSV_INT_SRCS-1:0] : 5'h00;
	wire [`PSV_INT_SRCS-1:0] clr_mask = sw_clr | (take_int ? int_grant : 5'h00);
	// a new event in the cycle of its clear keeps the flag set
	wire [`PSV_INT_SRCS-1:0] nxt_flag = (flag_ff & ~clr_mask) | int_evt; // RULE19 RULE20

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			lowb_pend_ff <= 1'b0;
		else if (wr_lowb)
			lowb_pend_ff <= 1'b1;
		else if (lowb_apply)
			lowb_pend_ff <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			lowb_data_ff <= 8'h00;
		else if (wr_lowb)
			lowb_data_ff <= wdata_ff[7:0]; // RULE14
	end

	// acknowledge masks further interrupts until a reti or a software write to the global enable bit sets it again
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			{both_edge_ff, src_en_ff, glob_en_ff} <= `PSV_EN_RESET;
		else if (take_int)
			glob_en_ff <= 1'b0;
		else if (cyc_end & op_reti)
			glob_en_ff <= 1'b1;
		else if (wr_en)
		begin
			glob_en_ff <= wdata_ff[`PSV_EN_GLOBAL];
			src_en_ff <= wdata_ff[`PSV_EN_SRC_MSB:`PSV_EN_SRC_LSB];
			both_edge_ff <= wdata_ff[`PSV_EN_BOTH_EDGE];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			flag_ff <= `PSV_FLAG_RESET;
			int_ack_ff <= 1'b0;
		end
		else
		begin
			flag_ff <= nxt_flag;
			int_ack_ff <= take_int;
		end
	end

	// reset value is high, the pin idles high
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			{int_s1_ff, int_s2_ff, int_s3_ff} <= 3'h7;
		else
			{int_s1_ff, int_s2_ff, int_s3_ff} <= {int_n_pin, int_s1_ff, int_s2_ff};
	end

	// ----------------------------------------
	// axi4-lite write channels
	// ----------------------------------------
	wire aw_take = s_axi_awvalid & awready_ff;
	wire w_take = s_axi_wvalid & wready_ff;
	wire b_done = bvalid_ff & s_axi_bready;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
		end
		else
		begin
			aw_held_ff <= (aw_held_ff | aw_take) & ~wr_fire;
			w_held_ff <= (w_held_ff | w_take) & ~wr_fire;
			awready_ff <= (awready_ff & ~aw_take) | b_done;
			wready_ff <= (wready_ff & ~w_take) | b_done;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (aw_take)
			aw_addr_ff <= s_axi_awaddr;
		if (w_take)
		begin
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `PSV_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_ff <= 1'b1;
			bresp_ff <= hit_w_any ? `PSV_RESP_OKAY : `PSV_RESP_SLVERR;
		end
		else if (b_done)
			bvalid_ff <= 1'b0;
	end

	// ----------------------------------------
	// axi4-lite read channels
	// ----------------------------------------
	wire ar_take = s_axi_arvalid & arready_ff;
	wire r_done = rvalid_ff & s_axi_rready;
	wire hit_r_lowb = (s_axi_araddr == `PSV_ADDR(`PSV_IDX_PC_LOW));
	wire hit_r_en = (s_axi_araddr == `PSV_ADDR(`PSV_IDX_INT_EN));
	wire hit_r_flag = (s_axi_araddr == `PSV_ADDR(`PSV_IDX_INT_FLAG));
	wire hit_r_stat = (s_axi_araddr == `PSV_ADDR(`PSV_IDX_STATUS));
	wire hit_r_any = hit_r_lowb | hit_r_en | hit_r_flag | hit_r_stat;
	wire [31:0] rd_mux =
		hit_r_lowb ? {24'h000000, pc_ff[7:0]} :
		hit_r_en ? {25'h0000000, both_edge_ff, src_en_ff, glob_en_ff} :
		hit_r_flag ? {27'h0000000, flag_ff} :
		hit_r_stat ? {11'h000, core.full, core.count, 3'h0, pc_ff} :
		32'h00000000;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `PSV_RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_mux;
			rresp_ff <= hit_r_any ? `PSV_RESP_OKAY : `PSV_RESP_SLVERR;
		end
		else if (r_done)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rom_addr = pc_ff; // RULE5 RULE17
	assign instr_word = instr_word_ff;
	assign instr_addr = instr_addr_ff;
	assign instr_valid = instr_valid_ff;
	assign phase = core.phase;
	assign int_ack = int_ack_ff;
	assign stack_full = core.full;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule // psv_sequencer

// ### psv_sequencer_asserts.sv
// assertions on the sequencer ports: phase timing, pipeline, transfers, vectors
// assumes it is bound onto psv_sequencer and sees only its ports
`timescale 1ns/1ps
`include "psv_consts.svh"

module psv_sequencer_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// pipeline
	input wire logic [`PSV_PC_W-1:0] rom_addr,
	input wire logic [`PSV_ROM_W-1:0] rom_data,
	input wire logic [`PSV_ROM_W-1:0] instr_word,
	input wire logic [`PSV_PC_W-1:0] instr_addr,
	input wire logic instr_valid,
	input wire logic [`PSV_PHASES-1:0] phase,
	input wire logic [2:0] xfer_op,
	input wire logic [`PSV_PC_W-1:0] xfer_target,
	// interrupt
	input wire logic int_ack
);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	phase_rotate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase == 4'h1 |=> phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8 ##1 phase == 4'h1)
		else $error("phase sequence broken");
	valid_stands_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$changed(instr_valid) |-> phase == 4'h1)
		else $error("instruction cycle not four clocks");
	addr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!phase[3] |=> $stable(rom_addr))
		else $error("fetch address moved mid cycle");
	pc_advance_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase[3] ##1 instr_valid |-> rom_addr == $past(rom_addr) + 13'h1)
		else $error("pc did not advance by one");
	fetch_pipe_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase[3] |=> instr_word == $past(rom_data) && instr_addr == $past(rom_addr))
		else $error("fetched word not handed to execute");
	jump_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase[3] && instr_valid && (xfer_op == 3'h1 || xfer_op == 3'h2) |=> !instr_valid && rom_addr == $past(xfer_target))
		else $error("jump target not loaded");
	skip_two_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		phase[3] && instr_valid && xfer_op == 3'h5 |=> !instr_valid && rom_addr == $past(instr_addr) + 13'h2)
		else $error("skip did not land on pc plus two");
	ack_vector_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		int_ack |-> !instr_valid && rom_addr inside {13'h0004, 13'h0008, 13'h000C, 13'h0010, 13'h0014})
		else $error("acknowledge without vector");
	ack_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		int_ack |=> !int_ack)
		else $error("acknowledge longer than one clock");
	// reset itself is the cause here, so this one has no disable
	reset_clear_a: assert property (@(posedge core_clk)
		sys_rst |=> rom_addr == 13'h0 && phase == 4'h1 && !instr_valid && !int_ack)
		else $error("reset did not clear pc");
endmodule // psv_sequencer_asserts

bind psv_sequencer psv_sequencer_asserts u_chk (.core_clk, .sys_rst, .rom_addr, .rom_data, .instr_word,
	.instr_addr, .instr_valid, .phase, .xfer_op, .xfer_target, .int_ack);

// ### psv_stack.sv
// eight-level return-address stack; software sees only its count and full flag, through the status register
// assumes push and pop never come in the same cycle
`timescale 1ns/1ps
`include "psv_consts.svh"

module psv_stack (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// stack port
	psv_core_if.stack core
);
	psv_pkg::psv_pc_t mem_ff [0:7];
	logic [2:0] ptr_ff;
	logic [3:0] cnt_ff;
	logic full_ff;
	logic [2:0] nxt_ptr;
	logic [3:0] nxt_cnt;
	wire can_pop = core.pop & (cnt_ff != 4'h0);

	// a push on a full stack wraps and overwrites the oldest entry
	assign nxt_ptr = core.push ? ptr_ff + 3'h1 : can_pop ? ptr_ff - 3'h1 : ptr_ff;
	assign nxt_cnt = (core.push & ~full_ff) ? cnt_ff + 4'h1 : can_pop ? cnt_ff - 4'h1 : cnt_ff;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ptr_ff <= 3'h0;
			cnt_ff <= 4'h0;
			full_ff <= 1'b0;
		end
		else
		begin
			ptr_ff <= nxt_ptr;
			cnt_ff <= nxt_cnt;
			full_ff <= (nxt_cnt == `PSV_STACK_DEPTH);
		end
	end

	// storage needs no reset: an empty stack is never read for meaning
	always_ff @(posedge core_clk)
	begin
		if (core.push)
			mem_ff[ptr_ff] <= core.push_data; // RULE18
	end

	assign core.top_data = mem_ff[ptr_ff - 3'h1]; // RULE16
	assign core.full = full_ff;
	assign core.count = cnt_ff;
endmodule // psv_stack
